// file: hw/serial_eeprom_i2c_target.sv
// Two-wire target of a 64-kilobit serial EEPROM with write FIFO
`default_nettype none

// ****************************************
// Write data FIFO
// ****************************************
module eeprom_fifo #(
    parameter int WIDTH = eeprom_pkg::FIFO_WIDTH,
    parameter int DEPTH = eeprom_pkg::FIFO_DEPTH
) (
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] store [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             push;
    logic             pop;

    assign in_ready  = count != (AW+1)'(DEPTH);
    assign out_valid = count != '0;
    assign out_data  = store[rd_ptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            store[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// ****************************************
// Target top level
// ****************************************
module serial_eeprom_i2c_target #(
    parameter int PROG_CYCLES = eeprom_pkg::PROG_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    input  wire logic [2:0] chip_select_straps,
    input  wire logic       write_inhibit,
    output logic            standby,
    output logic            program_busy,
    output logic            id_page_locked
);
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_DEV  = 6'h02,
        ST_AHI  = 6'h04,
        ST_ALO  = 6'h08,
        ST_WDAT = 6'h10,
        ST_RDAT = 6'h20
    } proto_e;

    localparam int AW = eeprom_pkg::ADDR_W;
    localparam int PW = eeprom_pkg::PAGE_W;

    logic [7:0]    mem    [eeprom_pkg::MEM_BYTES];
    logic [7:0]    idmem  [eeprom_pkg::PAGE_BYTES];
    logic [7:0]    pbuf   [eeprom_pkg::PAGE_BYTES];
    logic [31:0]   pvalid;

    logic [5:0]    s1;
    logic [5:0]    s2;
    logic [5:0]    s3;
    logic [5:0]    filt;
    logic          scl_d;
    logic          sda_d;
    logic          scl;
    logic          sda;
    logic          wp;
    logic          scl_rise;
    logic          scl_fall;
    logic          start_seen;
    logic          stop_seen;

    proto_e        state;
    logic [3:0]    cnt;
    logic [7:0]    shreg;
    logic [7:0]    addr_hi;
    logic [AW-1:0] addr_ptr;
    logic [AW-PW-1:0] page_base;
    logic          use_id;
    logic          write_id;
    logic          rw_read;
    logic          acked;
    logic          mack;
    logic          dirty;
    logic          lock_req;
    logic [7:0]    rd_byte;
    logic          dev_match;
    logic          wr_ok;
    logic          lock_cmd;

    logic          f_in_valid;
    logic          f_in_ready;
    logic [eeprom_pkg::FIFO_WIDTH-1:0] f_in_data;
    logic          f_out_valid;
    logic          f_out_ready;
    logic [eeprom_pkg::FIFO_WIDTH-1:0] f_out_data;

    logic [31:0]   prog_cnt;
    logic          committing;
    logic [PW-1:0] cidx;

    // ****************************************
    // Pin sampling
    // ****************************************
    // floating straps low: the pad bias resolves them before they arrive here
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s1    <= eeprom_pkg::PIN_RST;
            s2    <= eeprom_pkg::PIN_RST;
            s3    <= eeprom_pkg::PIN_RST;
            filt  <= eeprom_pkg::PIN_RST;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            s1    <= {chip_select_straps, write_inhibit, sda_in, scl_in};
            s2    <= s1;
            s3    <= s2;
            // A change counts once the second and third stages agree
            filt  <= (s3 & ~(s2 ^ s3)) | (filt & (s2 ^ s3));
            scl_d <= filt[0];
            sda_d <= filt[1];
        end
    end

    assign scl      = filt[0];
    assign sda      = filt[1];
    assign wp       = filt[2];
    assign scl_rise = scl && !scl_d;
    assign scl_fall = !scl && scl_d;
    assign start_seen = scl && scl_d && sda_d && !sda;
    assign stop_seen  = scl && scl_d && !sda_d && sda;

    assign dev_match = (shreg[7:4] == eeprom_pkg::TYPE_MEM || shreg[7:4] == eeprom_pkg::TYPE_ID)
                       && shreg[3:1] == filt[5:3];
    // bit 10 picks lock versus page write
    assign lock_cmd  = write_id && addr_hi[eeprom_pkg::LOCK_SEL_BIT];
    assign wr_ok     = !(write_id && !lock_cmd && id_page_locked);
    // reads wrap over the whole array
    assign rd_byte   = use_id ? idmem[addr_ptr[PW-1:0]] : mem[addr_ptr];

    assign f_out_ready = !committing;
    // open drain: the output level is always low
    assign sda_out     = 1'b0;

    eeprom_fifo #(
        .WIDTH (eeprom_pkg::FIFO_WIDTH),
        .DEPTH (eeprom_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .in_valid  (f_in_valid),
        .in_ready  (f_in_ready),
        .in_data   (f_in_data),
        .out_valid (f_out_valid),
        .out_ready (f_out_ready),
        .out_data  (f_out_data)
    );

    // ****************************************
    // Protocol engine
    // ****************************************
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state      <= ST_IDLE;
            cnt        <= 4'h0;
            shreg      <= 8'h00;
            addr_hi    <= 8'h00;
            addr_ptr   <= '0;
            page_base  <= '0;
            use_id     <= 1'b0;
            write_id   <= 1'b0;
            rw_read    <= 1'b0;
            acked      <= 1'b0;
            mack       <= 1'b0;
            sda_oe     <= 1'b0;
            f_in_valid <= 1'b0;
            f_in_data  <= '0;
            dirty      <= 1'b0;
            lock_req   <= 1'b0;
        end else begin
            f_in_valid <= 1'b0;
            if (program_busy) begin
                // inputs ignored while programming; polls go unanswered
                state  <= ST_IDLE;
                sda_oe <= 1'b0;
                dirty  <= 1'b0;
                if (committing && cidx == PW'(eeprom_pkg::PAGE_BYTES - 1)) begin
                    lock_req <= 1'b0;
                end
            end else if (start_seen) begin
                // a repeated start keeps the loaded address
                state  <= ST_DEV;
                cnt    <= 4'h0;
                sda_oe <= 1'b0;
            end else if (stop_seen) begin
                state  <= ST_IDLE;
                sda_oe <= 1'b0;
            end else if (state != ST_IDLE) begin
                if (scl_rise) begin
                    cnt <= cnt + 4'h1;
                    if (cnt < eeprom_pkg::ACK_CNT && state != ST_RDAT) begin
                        shreg <= {shreg[6:0], sda};
                    end
                    if (cnt == eeprom_pkg::ACK_CNT && state == ST_RDAT) begin
                        mack <= !sda;
                    end
                end else if (scl_fall) begin
                    // every drive change happens with SCL low
                    if (state == ST_RDAT) begin
                        if (cnt == eeprom_pkg::ACK_CNT) begin
                            sda_oe   <= 1'b0;
                            // counter moves past the byte just read
                            addr_ptr <= addr_ptr + 1'b1;
                        end else if (cnt == eeprom_pkg::END_CNT) begin
                            cnt <= 4'h0;
                            if (mack) begin
                                shreg  <= rd_byte;
                                sda_oe <= !rd_byte[7];
                            end else begin
                                state <= ST_IDLE;
                            end
                        end else begin
                            sda_oe <= !shreg[6];
                            shreg  <= {shreg[6:0], 1'b0};
                        end
                    end else if (cnt == eeprom_pkg::ACK_CNT) begin
                        unique case (state)
                            ST_DEV: begin
                                // ack only on a match; direction bit
                                acked   <= dev_match;
                                sda_oe  <= dev_match;
                                rw_read <= shreg[0];
                                use_id  <= shreg[7:4] == eeprom_pkg::TYPE_ID;
                            end
                            ST_AHI: begin
                                acked   <= 1'b1;
                                sda_oe  <= 1'b1;
                                addr_hi <= shreg;
                            end
                            ST_ALO: begin
                                acked     <= 1'b1;
                                sda_oe    <= 1'b1;
                                // top three bits dropped; 13-bit address
                                addr_ptr  <= {addr_hi[AW-9:0], shreg};
                                page_base <= {addr_hi[AW-9:0], shreg[7:PW]};
                                write_id  <= use_id;
                            end
                            default: begin
                                acked  <= wr_ok && f_in_ready;
                                sda_oe <= wr_ok && f_in_ready;
                                if (wr_ok && f_in_ready) begin
                                    addr_ptr[PW-1:0] <= addr_ptr[PW-1:0] + 1'b1;
                                    // inhibited bytes are acked and dropped
                                    if (!wp && lock_cmd) begin
                                        // lock needs data bit 1 set
                                        lock_req <= lock_req || shreg[eeprom_pkg::LOCK_DATA_BIT];
                                        dirty    <= dirty || shreg[eeprom_pkg::LOCK_DATA_BIT];
                                    end else if (!wp) begin
                                        // nothing reaches the buffer under inhibit
                                        // Offset captured before it advances
                                        f_in_valid <= 1'b1;
                                        f_in_data  <= {addr_ptr[PW-1:0], shreg};
                                        dirty      <= 1'b1;
                                    end
                                end
                            end
                        endcase
                    end else if (cnt == eeprom_pkg::END_CNT) begin
                        cnt    <= 4'h0;
                        sda_oe <= 1'b0;
                        if (!acked) begin
                            state <= ST_IDLE;
                        end else begin
                            unique case (state)
                                ST_DEV: begin
                                    if (rw_read) begin
                                        state  <= ST_RDAT;
                                        shreg  <= rd_byte;
                                        sda_oe <= !rd_byte[7];
                                    end else begin
                                        state <= ST_AHI;
                                    end
                                end
                                ST_AHI:  state <= ST_ALO;
                                // further bytes keep the page write open
                                default: state <= ST_WDAT;
                            endcase
                        end
                    end
                end
            end
        end
    end

    // ****************************************
    // Programming cycle
    // ****************************************
    // programming starts only at the stop after written data
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            program_busy <= 1'b0;
            committing   <= 1'b0;
            prog_cnt     <= 32'h0;
            cidx         <= '0;
        end else if (!program_busy) begin
            if (stop_seen && dirty) begin
                program_busy <= 1'b1;
                prog_cnt     <= 32'h0;
            end
        end else if (!committing) begin
            // timed wait, then the page is copied in
            if (prog_cnt == 32'(PROG_CYCLES - 1)) begin
                committing <= 1'b1;
                cidx       <= '0;
            end else begin
                prog_cnt <= prog_cnt + 32'h1;
            end
        end else begin
            cidx <= cidx + 1'b1;
            if (cidx == PW'(eeprom_pkg::PAGE_BYTES - 1)) begin
                committing   <= 1'b0;
                program_busy <= 1'b0;
            end
        end
    end

    // Staging buffer fills from the FIFO; it stalls only during the copy
    always_ff @(posedge clk) begin
        if (f_out_valid && f_out_ready) begin
            pbuf[f_out_data[eeprom_pkg::FIFO_WIDTH-1:8]] <= f_out_data[7:0];
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pvalid <= 32'h0;
        end else if (committing && cidx == PW'(eeprom_pkg::PAGE_BYTES - 1)) begin
            pvalid <= 32'h0;
        end else if (f_out_valid && f_out_ready) begin
            pvalid[f_out_data[eeprom_pkg::FIFO_WIDTH-1:8]] <= 1'b1;
        end
    end

    // Array contents are not reset, as in a real nonvolatile part
    always_ff @(posedge clk) begin
        if (committing && pvalid[cidx]) begin
            if (write_id) begin
                idmem[cidx] <= pbuf[cidx];
            end else begin
                mem[{page_base, cidx}] <= pbuf[cidx];
            end
        end
    end

    // Lock survives until sys_rst only; no real nonvolatile storage here
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            id_page_locked <= 1'b0;
        end else if (committing && lock_req && cidx == PW'(eeprom_pkg::PAGE_BYTES - 1)) begin
            id_page_locked <= 1'b1;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            standby <= 1'b1;
        end else begin
            standby <= state == ST_IDLE && !program_busy;
        end
    end
endmodule
`default_nettype wire

// file: hw/eeprom_pkg.sv
// Constants shared by the serial EEPROM two-wire target
`default_nettype none
package eeprom_pkg;
    // ****************************************
    // Array geometry
    // ****************************************
    localparam int ADDR_W     = 13;
    localparam int PAGE_W     = 5;
    localparam int MEM_BYTES  = 8192;
    localparam int PAGE_BYTES = 32;
    // ****************************************
    // Device address word
    // ****************************************
    localparam logic [3:0] TYPE_MEM = 4'hA;
    localparam logic [3:0] TYPE_ID  = 4'hB;
    // Bit 10 of the word address sits at bit 2 of the high byte
    localparam int LOCK_SEL_BIT  = 2;
    localparam int LOCK_DATA_BIT = 1;
    // ****************************************
    // Bit framing
    // ****************************************
    localparam logic [3:0] ACK_CNT = 4'h8;
    localparam logic [3:0] END_CNT = 4'h9;
    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS   = 20;
    localparam int PROGRAM_TIME_NS = 3000000;
    // A longest time, so round down
    localparam int PROG_CYCLES     = PROGRAM_TIME_NS / CLK_PERIOD_NS;
    // ****************************************
    // Buffering and pin sampling
    // ****************************************
    localparam int FIFO_DEPTH = 8;
    localparam int FIFO_WIDTH = PAGE_W + 8;
    // Order {straps[2:0], write_inhibit, sda, scl}; idle bus is high
    localparam logic [5:0] PIN_RST = 6'h03;
endpackage
`default_nettype wire

// file: tb/eeprom_checker.sv
// Port-level assertions for the EEPROM two-wire target
`default_nettype none
module eeprom_checker #(
    parameter int PROG_CYCLES = 50
) (
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire logic       scl_in,
    input wire logic       sda_in,
    input wire logic       sda_out,
    input wire logic       sda_oe,
    input wire logic [2:0] chip_select_straps,
    input wire logic       write_inhibit,
    input wire logic       standby,
    input wire logic       program_busy,
    input wire logic       id_page_locked
);
    // ****************************************
    // Link and programming relations
    // ****************************************
    int busy_cnt;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    // Run length of the busy flag, so the window is bounded without a long repeat
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            busy_cnt <= 0;
        end else begin
            busy_cnt <= program_busy ? busy_cnt + 1 : 0;
        end
    end
    AST_OPEN_DRAIN: assert property (sda_out == 1'h0)
        else $error("sda_out not low");
    AST_OE_IN_LOW: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("sda_oe moved with scl high");
    AST_BUSY_QUIET: assert property (program_busy |-> !sda_oe)
        else $error("bus answered while programming");
    AST_BUSY_LEN: assert property ($fell(program_busy) |-> busy_cnt >= PROG_CYCLES)
        else $error("programming cycle too short");
    AST_BUSY_CAP: assert property (busy_cnt <= PROG_CYCLES + 33)
        else $error("programming cycle too long");
    AST_STANDBY_OFF: assert property (program_busy |-> !standby)
        else $error("standby while programming");
    AST_STANDBY_BACK: assert property ($fell(program_busy) |-> ##[0:2] standby)
        else $error("no standby after programming");
    AST_WI_BLOCKS: assert property ($rose(program_busy) |-> !write_inhibit)
        else $error("programming under write inhibit");
    AST_LOCK_KEPT: assert property (!$fell(id_page_locked))
        else $error("lock flag dropped");
    AST_IDLE_QUIET: assert property (standby |-> !sda_oe)
        else $error("sda pulled while in standby");
    COV_PROG: cover property ($rose(program_busy));
    COV_LOCK: cover property ($rose(id_page_locked));
    COV_ACK: cover property ($rose(sda_oe));
endmodule
`default_nettype wire

// file: tb/i2c_ctrl_model.sv
// Two-wire bus controller model for the EEPROM bench
`default_nettype none
module i2c_ctrl_model (
    output var logic scl,
    output var logic sda_low,
    input  wire logic sda
);
    timeunit 1ns;
    timeprecision 100ps;
    // ****************************************
    // Bus cycles, 240 ns a bit to leave the target's sync delay room
    // ****************************************
    initial begin
        scl     = 1'h1;
        sda_low = 1'h0;
    end
    // data moves only in the low phase
    task automatic bit_io(input logic b, output logic r);
        sda_low = !b;
        #70;
        scl = 1'h1;
        #100;
        r = sda;
        scl = 1'h0;
        #70;
    endtask
    // start; odd offset keeps pin edges off the clk edges
    task automatic start();
        #7;
        sda_low = 1'h0;
        #100;
        scl = 1'h1;
        #100;
        sda_low = 1'h1;
        #100;
        scl = 1'h0;
        #70;
    endtask
    // stop; the wire then floats back high
    task automatic stop();
        sda_low = 1'h1;
        #100;
        scl = 1'h1;
        #100;
        sda_low = 1'h0;
        #100;
    endtask
    // msb first, ninth bit is the target's answer
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], r);
        end
        bit_io(1'h1, r);
        ack = !r;
    endtask
    // an ack from here keeps a read going
    task automatic rbyte(input logic more, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'h1, r);
            b[i] = r;
        end
        bit_io(!more, r);
    endtask
    // clock until the line is seen high, at most nine times
    task automatic recover();
        logic r;
        r = 1'h0;
        for (int i = 0; i < 9 && r !== 1'h1; i++) begin
            bit_io(1'h1, r);
        end
    endtask
endmodule
`default_nettype wire

// file: tb/tb_top.sv
// Self-checking bench for the EEPROM two-wire target
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int PROG = 200;
    logic       clk;
    logic       sys_rst;
    logic [2:0] straps;
    logic       wi;
    logic       a;
    logic [7:0] b;
    logic [7:0] pd [6];
    int         err_total;
    int         check_count;
    wire        scl;
    wire        sda_low;
    wire        sda;
    wire        sda_oe;
    wire        sda_out;
    wire        standby;
    wire        program_busy;
    wire        id_page_locked;
    // ****************************************
    // Wiring, tasks and scenarios
    // ****************************************
    // wired-AND with a pull-up
    assign sda = !(sda_low || (sda_oe && !sda_out));
    serial_eeprom_i2c_target #(.PROG_CYCLES(PROG)) dut (
        .clk(clk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe(sda_oe), .chip_select_straps(straps), .write_inhibit(wi), .standby(standby),
        .program_busy(program_busy), .id_page_locked(id_page_locked)
    );
    i2c_ctrl_model ctl (.scl(scl), .sda_low(sda_low), .sda(sda));
    initial begin
        clk = 1'h0;
        forever #10 clk = !clk;
    end
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
            err_total++;
        end
    endtask
    task automatic dev(input logic [3:0] kind, input logic rw, output logic ack);
        ctl.start();
        ctl.wbyte({kind, straps, rw}, ack);
    endtask
    task automatic waddr(input logic [3:0] kind, input logic [7:0] hi, input logic [7:0] lo);
        logic k;
        dev(kind, 1'h0, k);
        check("dev_ack", 8'(k), 8'h01);
        ctl.wbyte(hi, k);
        check("hi_ack", 8'(k), 8'h01);
        ctl.wbyte(lo, k);
        check("lo_ack", 8'(k), 8'h01);
    endtask
    task automatic rd(input logic [3:0] kind, input logic [7:0] hi, input logic [7:0] lo,
                      output logic [7:0] d);
        logic k;
        waddr(kind, hi, lo);
        dev(kind, 1'h1, k);
        check("rd_ack", 8'(k), 8'h01);
        ctl.rbyte(1'h0, d);
        ctl.stop();
    endtask
    task automatic wr1(input logic [3:0] kind, input logic [7:0] hi, input logic [7:0] lo,
                       input logic [7:0] d, output logic ack);
        waddr(kind, hi, lo);
        ctl.wbyte(d, ack);
        ctl.stop();
    endtask
    task automatic wait_prog();
        int n;
        n = 0;
        repeat (4) @(negedge clk);
        check("busy", 8'(program_busy), 8'h01);
        while (program_busy !== 1'h0 && n < PROG + 40) begin
            @(negedge clk);
            n++;
        end
        check("busy_end", 8'(program_busy), 8'h00);
        repeat (2) @(negedge clk);
    endtask
    task automatic t_mismatch();
        ctl.start();
        ctl.wbyte({eeprom_pkg::TYPE_MEM, straps ^ 3'h1, 1'h0}, a);
        check("strap_nack", 8'(a), 8'h00);
        dev(4'h2, 1'h0, a);
        check("type_nack", 8'(a), 8'h00);
        ctl.stop();
        repeat (8) @(negedge clk);
        check("standby", 8'(standby), 8'h01);
    endtask
    task automatic t_page();
        waddr(eeprom_pkg::TYPE_MEM, 8'hFF, 8'hFC);
        for (int i = 0; i < 6; i++) begin
            ctl.wbyte(pd[i], a);
            check("page_ack", 8'(a), 8'h01);
        end
        ctl.stop();
        dev(eeprom_pkg::TYPE_MEM, 1'h0, a);
        check("poll_busy", 8'(a), 8'h00);
        ctl.stop();
        wait_prog();
        dev(eeprom_pkg::TYPE_MEM, 1'h0, a);
        check("poll_done", 8'(a), 8'h01);
        ctl.stop();
    endtask
    task automatic t_read();
        rd(eeprom_pkg::TYPE_MEM, 8'h1F, 8'hE0, b);
        check("page_wrap", b, pd[4]);
        dev(eeprom_pkg::TYPE_MEM, 1'h1, a);
        ctl.rbyte(1'h0, b);
        ctl.stop();
        check("current", b, pd[5]);
        wr1(eeprom_pkg::TYPE_MEM, 8'hE0, 8'h00, 8'h5A, a);
        check("byte_ack", 8'(a), 8'h01);
        wait_prog();
        waddr(eeprom_pkg::TYPE_MEM, 8'h1F, 8'hFE);
        dev(eeprom_pkg::TYPE_MEM, 1'h1, a);
        ctl.rbyte(1'h1, b);
        check("seq0", b, pd[2]);
        ctl.rbyte(1'h1, b);
        check("seq1", b, pd[3]);
        ctl.rbyte(1'h0, b);
        check("seq_wrap", b, 8'h5A);
        ctl.stop();
    endtask
    task automatic t_inhibit();
        wi = 1'h1;
        repeat (4) @(negedge clk);
        wr1(eeprom_pkg::TYPE_MEM, 8'h1F, 8'hE0, 8'h00, a);
        check("wi_ack", 8'(a), 8'h01);
        repeat (20) @(negedge clk);
        check("wi_busy", 8'(program_busy), 8'h00);
        wi = 1'h0;
        rd(eeprom_pkg::TYPE_MEM, 8'h1F, 8'hE0, b);
        check("wi_keep", b, pd[4]);
    endtask
    task automatic t_id();
        wr1(eeprom_pkg::TYPE_ID, 8'h00, 8'h03, 8'h77, a);
        check("id_ack", 8'(a), 8'h01);
        wait_prog();
        rd(eeprom_pkg::TYPE_ID, 8'hF8, 8'h03, b);
        check("id_read", b, 8'h77);
        wr1(eeprom_pkg::TYPE_ID, 8'h04, 8'h00, 8'h02, a);
        wait_prog();
        check("locked", 8'(id_page_locked), 8'h01);
        wr1(eeprom_pkg::TYPE_ID, 8'h00, 8'h03, 8'h11, a);
        check("id_nack", 8'(a), 8'h00);
        rd(eeprom_pkg::TYPE_ID, 8'h00, 8'h03, b);
        check("id_kept", b, 8'h77);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        sys_rst = 1'h1;
        straps = 3'h5;
        wi = 1'h0;
        err_total = 0;
        check_count = 0;
        pd = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66};
        repeat (16) @(negedge clk);
        sys_rst = 1'h0;
        repeat (8) @(negedge clk);
        check("rst_oe", 8'(sda_oe), 8'h00);
        check("rst_standby", 8'(standby), 8'h01);
        check("rst_lock", 8'(id_page_locked), 8'h00);
        ctl.recover();
        t_mismatch();
        t_page();
        t_read();
        t_inhibit();
        t_id();
        print_verdict();
    end
    // The full sequence needs well under half of this span
    initial begin
        #1ms;
        err_total++;
        print_verdict();
    end
endmodule
bind serial_eeprom_i2c_target eeprom_checker #(.PROG_CYCLES(PROG_CYCLES)) chk (
    .clk(clk), .sys_rst(sys_rst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .chip_select_straps(chip_select_straps), .write_inhibit(write_inhibit),
    .standby(standby), .program_busy(program_busy), .id_page_locked(id_page_locked)
);
`default_nettype wire
